// *** hw/sram_decode_pkg.sv ***
// Constants shared by the synchronous SRAM access-decode design
package sram_decode_pkg;
  // ==========================================================================
  // Array geometry
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned DATA_W  = 18;
  localparam int unsigned LANES   = 2;
  localparam int unsigned LANE_W  = DATA_W / LANES;
  localparam int unsigned DEPTH   = 1 << ADDR_W;
  localparam int unsigned BURST_W = 2;

  // ==========================================================================
  // Values after reset
  localparam logic               SEL_RST   = 1'b0;
  localparam logic               WR_RST    = 1'b0;
  localparam logic [BURST_W-1:0] CNT_RST   = 2'h0;
  localparam logic [LANES-1:0]   LANES_RST = 2'h0;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;
  localparam logic [DATA_W-1:0]  DATA_RST  = 18'h0_0000;

  // Burst order select level that chooses linear counting
  localparam logic ORDER_LINEAR = 1'b0;
endpackage

// *** hw/sram_array_if.sv ***
// Carrier between the access decode and the storage array
`timescale 1ns/10ps
interface sram_array_if;
  logic [sram_decode_pkg::ADDR_W-1:0] addr;
  logic [sram_decode_pkg::DATA_W-1:0] wdata;
  logic [sram_decode_pkg::LANES-1:0]  wlane;
  logic                               wen;
  logic [sram_decode_pkg::DATA_W-1:0] rdata;

  modport decode (output addr, output wdata, output wlane, output wen,
                  input rdata);
  modport array  (input addr, input wdata, input wlane, input wen,
                  output rdata);
endinterface

// *** hw/sram_store.sv ***
// Storage array with byte-lane writes and unregistered read
`timescale 1ns/10ps
module sram_store (
  // Clock
  input  wire logic clk,
  // Port from the decode logic
  sram_array_if.array port_a
);
  // ==========================================================================
  // Array
  logic [sram_decode_pkg::DATA_W-1:0] mem [sram_decode_pkg::DEPTH];

  // Self-timed write: committed one edge after the write was registered
  always_ff @(posedge clk) begin
    for (int i = 0; i < sram_decode_pkg::LANES; i++) begin
      if (port_a.wen && port_a.wlane[i]) begin
        mem[port_a.addr][i*sram_decode_pkg::LANE_W +:
                         sram_decode_pkg::LANE_W] <=
          port_a.wdata[i*sram_decode_pkg::LANE_W +: sram_decode_pkg::LANE_W];
      end
    end
  end

  // Flow-through read, no output stage
  assign port_a.rdata = mem[port_a.addr];
endmodule

// *** hw/sync_sram_access_decode.sv ***
// Access decode of a flow-through synchronous SRAM
`timescale 1ns/10ps
module sync_sram_access_decode (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rstn,
  // Address and strobes
  input  wire logic [sram_decode_pkg::ADDR_W-1:0] addr,
  input  wire logic                               processor_addr_strobe,
  input  wire logic                               controller_addr_strobe,
  input  wire logic                               burst_advance,
  input  wire logic                               burst_order_select,
  // Chip selects
  input  wire logic                               chip_select_one_low,
  input  wire logic                               chip_select_two_high,
  input  wire logic                               chip_select_three_low,
  // Write controls, all active low
  input  wire logic [sram_decode_pkg::LANES-1:0]  byte_lane_write,
  input  wire logic                               write_enable_low,
  input  wire logic                               global_write_low,
  // Asynchronous output enable, active low
  input  wire logic                               output_enable_low,
  // Data bus split into its three signals
  input  wire logic [sram_decode_pkg::DATA_W-1:0] dq_in,
  output logic      [sram_decode_pkg::DATA_W-1:0] dq_out,
  output logic                                    dq_oe_n
);
  // ==========================================================================
  // Decode helpers
  // Lanes written in a cycle; zero means the cycle is a read
  function automatic logic [sram_decode_pkg::LANES-1:0] lane_decode(
    input logic                              gw_n,
    input logic                              we_n,
    input logic [sram_decode_pkg::LANES-1:0] bl_n
  );
    logic [sram_decode_pkg::LANES-1:0] res;
    res = '0;
    if (!gw_n) begin
      res = '1;
    end else if (!we_n) begin
      res = ~bl_n;
    end
    return res;
  endfunction

  // Low address bits for the current beat of a burst
  function automatic logic [sram_decode_pkg::BURST_W-1:0] beat_addr(
    input logic                                base,
    input logic                                order,
    input logic [sram_decode_pkg::BURST_W-1:0] cnt,
    input logic [sram_decode_pkg::BURST_W-1:0] lsb
  );
    logic [sram_decode_pkg::BURST_W-1:0] res;
    res = lsb + cnt;
    if (order != sram_decode_pkg::ORDER_LINEAR) begin
      res = lsb ^ cnt;
    end
    return base ? res : lsb;
  endfunction

  // ==========================================================================
  // Input decode, all levels sampled at the rising edge
  logic strobe;
  logic cs_ok;
  logic [sram_decode_pkg::LANES-1:0] lanes_now;

  assign strobe    = !processor_addr_strobe || !controller_addr_strobe;
  assign cs_ok     = !chip_select_one_low && chip_select_two_high &&
                     !chip_select_three_low;
  assign lanes_now = lane_decode(global_write_low, write_enable_low,
                                 byte_lane_write);

  // ==========================================================================
  // Access state
  logic                                sel_ff,   nxt_sel;
  logic                                wr_ff,    nxt_wr;
  logic [sram_decode_pkg::LANES-1:0]   lanes_ff, nxt_lanes;
  logic [sram_decode_pkg::ADDR_W-1:0]  addr_ff,  nxt_addr;
  logic [sram_decode_pkg::BURST_W-1:0] cnt_ff,   nxt_cnt;
  logic [sram_decode_pkg::DATA_W-1:0]  wdata_ff, nxt_wdata;

  // Next access: a strobe reloads, otherwise advance may step the counter.
  // Write controls are decoded again on every edge, so a burst may mix
  // reads and writes under the selection held from its last strobe; the
  // chip selects are looked at only when a strobe is seen.
  always_comb begin
    nxt_sel   = sel_ff;
    nxt_addr  = addr_ff;
    nxt_cnt   = cnt_ff;
    nxt_wdata = dq_in;
    if (strobe) begin
      nxt_sel  = cs_ok;
      nxt_addr = addr;
      nxt_cnt  = sram_decode_pkg::CNT_RST;
    end else if (sel_ff && !burst_advance) begin
      nxt_cnt  = cnt_ff + 2'h1;
    end
    // Advance held high keeps the counter still, so strobes drive it
    nxt_lanes = nxt_sel ? lanes_now : sram_decode_pkg::LANES_RST;
    nxt_wr    = nxt_sel && (lanes_now != '0);
  end

  // Register the access state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sel_ff   <= sram_decode_pkg::SEL_RST;
      wr_ff    <= sram_decode_pkg::WR_RST;
      lanes_ff <= sram_decode_pkg::LANES_RST;
      cnt_ff   <= sram_decode_pkg::CNT_RST;
      addr_ff  <= sram_decode_pkg::ADDR_RST;
      wdata_ff <= sram_decode_pkg::DATA_RST;
    end else begin
      sel_ff   <= nxt_sel;
      wr_ff    <= nxt_wr;
      lanes_ff <= nxt_lanes;
      cnt_ff   <= nxt_cnt;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  // ==========================================================================
  // Array connection
  sram_array_if arr ();
  logic [sram_decode_pkg::ADDR_W-1:0] eff_addr;

  // The array sees the access one edge after decode, which is what lets
  // a write finish by itself at the following edge.
  // Burst order is a level, not registered; it must be tied firmly
  assign eff_addr = {addr_ff[sram_decode_pkg::ADDR_W-1:2],
                     beat_addr(1'b1, burst_order_select, cnt_ff,
                               addr_ff[1:0])};
  assign arr.addr  = eff_addr;
  assign arr.wdata = wdata_ff;
  assign arr.wlane = lanes_ff;
  assign arr.wen   = wr_ff;

  sram_store u_store (
    .clk    (clk),
    .port_a (arr)
  );

  // ==========================================================================
  // Data output
  // No output register: read data flows through in the access cycle
  // dq_out shows the array even with the driver off; the pads gate it
  assign dq_out  = arr.rdata;
  // Driver off during writes whatever output enable says; this also saves
  // the bus if the controller forgets to drop output enable early
  assign dq_oe_n = !(sel_ff && !wr_ff && !output_enable_low);

  // ==========================================================================
  // Checks
  chk_write_global: assert property (@(posedge clk) disable iff (!rstn)
    (strobe && cs_ok && !global_write_low) |=> (wr_ff && lanes_ff == '1))
    else $error("global write not decoded as write of both lanes");

  chk_write_lane: assert property (@(posedge clk) disable iff (!rstn)
    (strobe && cs_ok && global_write_low && !write_enable_low)
      |=> (lanes_ff == ~$past(byte_lane_write)))
    else $error("byte lane write decoded to wrong lanes");

  chk_read_only: assert property (@(posedge clk) disable iff (!rstn)
    (strobe && cs_ok && global_write_low && write_enable_low) |=> !wr_ff)
    else $error("read cycle decoded as write");

  chk_select_bad: assert property (@(posedge clk) disable iff (!rstn)
    (strobe && !cs_ok) |=> (!sel_ff && !wr_ff && dq_oe_n))
    else $error("device selected with wrong chip select pattern");

  chk_select_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!strobe) |=> (sel_ff == $past(sel_ff)))
    else $error("selection changed without address strobe");

  chk_oe_write: assert property (@(posedge clk) disable iff (!rstn)
    wr_ff |-> dq_oe_n)
    else $error("data driver enabled during write cycle");

  chk_fresh_addr: assert property (@(posedge clk) disable iff (!rstn)
    (strobe && cs_ok) |=> (eff_addr == $past(addr)))
    else $error("strobed address not used for the access");

  chk_count_hold: assert property (@(posedge clk) disable iff (!rstn)
    (!strobe && burst_advance) |=> $stable(eff_addr))
    else $error("address moved while advance held high");

  chk_flow_read: assert property (@(posedge clk) disable iff (!rstn)
    (strobe && cs_ok && !output_enable_low && lanes_now == '0)
      ##1 !output_enable_low |-> (!dq_oe_n && dq_out == arr.rdata))
    else $error("read data not driven in its access cycle");

  // A deselected part neither writes nor drives the bus
  chk_desel_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !sel_ff |-> (!wr_ff && dq_oe_n))
    else $error("deselected access wrote or drove the bus");

  // The processor strobe alone opens an access as well
  chk_proc_strobe: assert property (@(posedge clk) disable iff (!rstn)
    (!processor_addr_strobe && controller_addr_strobe && cs_ok) |=> sel_ff)
    else $error("processor strobe did not select the device");

  // Output enable high keeps the driver off, read or write
  chk_oe_high: assert property (@(posedge clk) disable iff (!rstn)
    (sel_ff && output_enable_low) |-> dq_oe_n)
    else $error("data driver on with output enable high");

  // With the counter free and linear order, each edge steps one word
  chk_linear_step: assert property (@(posedge clk) disable iff (!rstn)
    (!strobe && sel_ff && !burst_advance &&
     burst_order_select == sram_decode_pkg::ORDER_LINEAR)
      |=> (eff_addr[1:0] == $past(eff_addr[1:0]) + 2'h1))
    else $error("burst counter did not step by one word");
endmodule

// *** testbench/cache_ctrl_model.sv ***
// Cache controller model that drives the SRAM pins, non-burst from time zero and in bursts through strap
`timescale 1ns/10ps
module cache_ctrl_model (
  // Clock
  input  wire logic                               clk,
  // Address, strobes and selects {three, two, one}
  output logic      [sram_decode_pkg::ADDR_W-1:0] addr,
  output logic                                    ps_n,
  output logic                                    cs_n,
  output logic                                    adv_n,
  output logic                                    order,
  output logic      [2:0]                         sel,
  // Write controls and data
  output logic      [sram_decode_pkg::LANES-1:0]  bl_n,
  output logic                                    we_n,
  output logic                                    gw_n,
  output logic                                    oe_n,
  output logic      [sram_decode_pkg::DATA_W-1:0] dq_in
);
  logic [sram_decode_pkg::DATA_W-1:0] last = 18'h0_0000;
  // Strapping that turns the counter off: a fresh address every cycle
  initial strap(1'b1, 1'b0, 1'b1, sram_decode_pkg::ORDER_LINEAR);
  // Strobe, advance and order levels; call only just after a falling edge
  task automatic strap(input logic p, input logic c, input logic a,
                       input logic o);
    ps_n  <= p;
    cs_n  <= c;
    adv_n <= a;
    // Any fixed level will do, but a floating pin would draw current
    order <= o;
  endtask
  // Present one access; call only just after a falling edge
  task automatic put(input logic [sram_decode_pkg::ADDR_W-1:0] a,
                     input logic [sram_decode_pkg::DATA_W-1:0] d,
                     input logic gw, input logic we,
                     input logic [1:0] bl, input logic [2:0] s,
                     input logic oe);
    logic [sram_decode_pkg::DATA_W-1:0] nd;
    // Inverse of the last word on reads, so stale data never matches
    nd = (gw & we) ? ~last : d;
    addr  <= a;
    sel   <= s;
    bl_n  <= bl;
    we_n  <= we;
    gw_n  <= gw;
    oe_n  <= oe;
    dq_in <= nd;
    last  <= nd;
  endtask
  // One whole cycle: drive, let the rising edge take it, return low
  task automatic cyc(input logic [sram_decode_pkg::ADDR_W-1:0] a,
                     input logic [sram_decode_pkg::DATA_W-1:0] d,
                     input logic gw, input logic we,
                     input logic [1:0] bl, input logic [2:0] s,
                     input logic oe);
    put(a, d, gw, we, bl, s, oe);
    @(negedge clk);
  endtask
  // Deselected and idle from time zero
  initial put('0, 18'h0_0000, 1'b1, 1'b1, 2'h3, 3'h7, 1'b1);
endmodule

// *** testbench/sync_sram_access_decode_tb.sv ***
// Self-checking bench for the SRAM access decode
`timescale 1ns/10ps
module sync_sram_access_decode_tb;
  typedef logic [sram_decode_pkg::ADDR_W-1:0] addr_t;
  typedef logic [sram_decode_pkg::DATA_W-1:0] word_t;
  localparam logic [2:0] CS_OK = 3'h2;
  localparam logic       LINEAR = sram_decode_pkg::ORDER_LINEAR;
  // ==========================================================================
  // Clock, reset, pins and counters
  logic       clk  = 1'b0;
  logic       rstn = 1'b0;
  addr_t      addr;
  word_t      dq_in;
  word_t      dq_out;
  logic [1:0] bl_n;
  logic [2:0] sel;
  logic       ps_n, cs_n, adv_n, order, we_n, gw_n, oe_n, dq_oe_n;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;
  sync_sram_access_decode sync_sram_access_decode_inst (
    .clk(clk), .rstn(rstn), .addr(addr),
    .processor_addr_strobe(ps_n), .controller_addr_strobe(cs_n),
    .burst_advance(adv_n), .burst_order_select(order),
    .chip_select_one_low(sel[0]), .chip_select_two_high(sel[1]),
    .chip_select_three_low(sel[2]), .byte_lane_write(bl_n),
    .write_enable_low(we_n), .global_write_low(gw_n),
    .output_enable_low(oe_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n));
  cache_ctrl_model cache_ctrl_model_inst (
    .clk(clk), .addr(addr), .ps_n(ps_n), .cs_n(cs_n), .adv_n(adv_n),
    .order(order), .sel(sel), .bl_n(bl_n), .we_n(we_n), .gw_n(gw_n),
    .oe_n(oe_n), .dq_in(dq_in));
  // 125 MHz clock
  always #4 clk = ~clk;
  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      stop_test();
    end
  end
  // ==========================================================================
  // Shared helpers
  task automatic chk(input string what, input word_t exp, input word_t got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input addr_t a, input word_t d);
    cache_ctrl_model_inst.cyc(a, d, 1'b0, 1'b1, 2'h3, CS_OK, 1'b1);
  endtask
  // Read sampled half a cycle after the edge that took the address
  task automatic rd(input addr_t a, input word_t e);
    cache_ctrl_model_inst.cyc(a, '0, 1'b1, 1'b1, 2'h3, CS_OK, 1'b0);
    chk("dq_out", e, dq_out);
    chk("dq_oe_n", 18'h0_0000, 18'(dq_oe_n));
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_lanes();
    wr(16'h0020, 18'h3_ffff);
    // Lane 0 only, then lanes low without the enable: no write
    cache_ctrl_model_inst.cyc(16'h0020, '0, 1'b1, 1'b0, 2'h2, CS_OK, 1'b1);
    cache_ctrl_model_inst.cyc(16'h0020, '0, 1'b1, 1'b1, 2'h0, CS_OK, 1'b1);
    rd(16'h0020, 18'h3_fe00);
    $display("test lanes done");
  endtask
  task automatic t_select();
    wr(16'h0030, 18'h1_2345);
    // Every wrong select pattern, odd ones as reads with enable low
    for (int i = 0; i < 8; i++) begin
      if (i != 2) begin
        cache_ctrl_model_inst.cyc(16'h0030, 18'h0_0abc, i[0], 1'b1, 2'h3,
                                  3'(i), 1'b0);
        chk("dq_oe_n", 18'h0_0001, 18'(dq_oe_n));
      end
    end
    rd(16'h0030, 18'h1_2345);
    $display("test select done");
  endtask
  task automatic t_oe_write();
    // Enable left low on purpose during a write
    cache_ctrl_model_inst.cyc(16'h0040, 18'h0_1111, 1'b0, 1'b1, 2'h3, CS_OK,
                              1'b0);
    chk("dq_oe_n", 18'h0_0001, 18'(dq_oe_n));
    rd(16'h0040, 18'h0_1111);
    $display("test oe_write done");
  endtask
  task automatic t_stream();
    // Back-to-back, one fresh address every cycle
    for (int i = 0; i < 4; i++) wr(16'h0050 + 16'(i), 18'h2_0100 + 18'(i));
    for (int i = 0; i < 4; i++) begin
      rd(16'h0050 + 16'(i), 18'h2_0100 + 18'(i));
    end
    $display("test stream done");
  endtask
  task automatic t_burst();
    // Four words to step through, written the plain non-burst way
    for (int i = 0; i < 4; i++) wr(16'h0060 + 16'(i), 18'h1_0060 + 18'(i));
    // Processor strobe alone starts an access at word one
    cache_ctrl_model_inst.strap(1'b0, 1'b1, 1'b1, LINEAR);
    rd(16'h0061, 18'h1_0061);
    // No strobe, advance low: linear steps, address pins ignored
    cache_ctrl_model_inst.strap(1'b1, 1'b1, 1'b0, LINEAR);
    for (int i = 2; i < 5; i++) begin
      rd(16'h0fff, 18'h1_0060 + 18'(i % 4));
    end
    // Advance high: the counter stands and the same word comes again
    cache_ctrl_model_inst.strap(1'b1, 1'b1, 1'b1, LINEAR);
    rd(16'h0fff, 18'h1_0060);
    // Restart, then step in interleaved order from a zero count
    cache_ctrl_model_inst.strap(1'b0, 1'b1, 1'b1, LINEAR);
    rd(16'h0061, 18'h1_0061);
    cache_ctrl_model_inst.strap(1'b1, 1'b1, 1'b0, ~LINEAR);
    rd(16'h0fff, 18'h1_0060);
    rd(16'h0fff, 18'h1_0063);
    rd(16'h0fff, 18'h1_0062);
    // Back to the non-burst strapping
    cache_ctrl_model_inst.strap(1'b1, 1'b0, 1'b1, LINEAR);
    $display("test burst done");
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_lanes();
    t_select();
    t_oe_write();
    t_stream();
    t_burst();
    stop_test();
  end
endmodule
